// [logic/rto_consts.vh]
// constants for the reloadable one-shot timer: offsets, fields, reset values
//------------------------------------------------------------
// Function
// - sixteen-bit up-counter wraps from all ones to zero and keeps counting
// - timer clock divided by prescale of 1 to 128 before advancing counter
// - reload one, prescale one is shortest; reload zero spans 65536 counts
// - clock-source field picks 32kHz peripheral clock or system clock
// - system clock counts in active and halt; peripheral clock also in stop
// - enabled input noise filter keeps working in halt; in stop only on peripheral clock
// - two independent compare channels share the one counter
// - enabled timer keeps counting in halt; clearing enable stops it
// - in stop on peripheral clock, timer interrupt requests wake and irq
// - system-clocked timer freezes in stop without reset, then resumes
// - clearing enable gates the timer logic; register access still works
// - on system clock every register is accessible at any time
// - at reload: interrupt, count set to one, enable cleared, stop
// - output pin inverts from reload until the next timer clock tick
// - time-out is (reload minus start) times prescale timer clocks
// - irq config value binary 11 restricts interrupts to reload events
// - clock-source bit one selects the 32kHz peripheral clock
//------------------------------------------------------------
`ifndef RTO_CONSTS_VH
`define RTO_CONSTS_VH

// register byte offsets
`define RTO_OFF_CTRL 8'h00
`define RTO_OFF_COUNT 8'h04
`define RTO_OFF_RELOAD 8'h08
`define RTO_OFF_CMP0 8'h0c
`define RTO_OFF_CMP1 8'h10
`define RTO_OFF_STAT 8'h14

// control field positions
`define RTO_CTRL_EN 0
`define RTO_CTRL_POL 1
`define RTO_CTRL_PRES_LO 2
`define RTO_CTRL_PRES_HI 4
`define RTO_CTRL_CLKSEL 5
`define RTO_CTRL_ICFG_LO 6
`define RTO_CTRL_ICFG_HI 7
`define RTO_CTRL_OUTEN 8
`define RTO_CTRL_FILTEN 9
`define RTO_CTRL_IRQEN 10
`define RTO_CTRL_RUN 11
`define RTO_CTRL_W 11

// status field positions
`define RTO_STAT_RELOAD 0
`define RTO_STAT_CMP0 1
`define RTO_STAT_CMP1 2
`define RTO_STAT_INCAP 3
`define RTO_STAT_W 4

// reset values and codes
`define RTO_CTRL_RST 11'h000
`define RTO_COUNT_RST 16'h0000
`define RTO_RELOAD_RST 16'h0000
`define RTO_COUNT_AFTER_RELOAD 16'h0001
`define RTO_ICFG_RELOAD_ONLY 2'h3
`define RTO_FILT_LEN 4
`define RTO_RESP_OKAY 2'h0
`define RTO_RESP_SLVERR 2'h2

`endif

// [logic/rto_prescale.v]
// prescaler: divides timer clock ticks by a power of two from 1 to 128
`timescale 1ns/1ps
module rto_prescale (
   aclk,
   aresetn,
   tick_in,
   run,
   sel,
   tick_out
);
   input wire aclk;
   input wire aresetn;
   input wire tick_in;
   input wire run;
   input wire [2:0] sel;
   output reg tick_out;

   reg [6:0] cnt_r;
   wire [6:0] limit;

   //------------------------------------------------------------
   // divider
   //------------------------------------------------------------
   assign limit = (7'h01 << sel) - 7'h01;

   // counter held at zero while stopped so each start sees a full divide
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= 7'h00;
         tick_out <= 1'b0;
      end else if (!run) begin
         cnt_r <= 7'h00;
         tick_out <= 1'b0;
      end else begin
         tick_out <= 1'b0;
         if (tick_in) begin
            if (cnt_r >= limit) begin
               cnt_r <= 7'h00;
               tick_out <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 7'h01;
            end
         end
      end
   end
endmodule

// [logic/rto_in_filter.v]
// timer input pin: two-flop synchroniser and optional majority-free noise filter
`timescale 1ns/1ps
module rto_in_filter #(
   parameter FILT_LEN = 4
) (
   aclk,
   aresetn,
   pin_in,
   filt_en,
   sample,
   level,
   edge_seen
);
   input wire aclk;
   input wire aresetn;
   input wire pin_in;
   input wire filt_en;
   input wire sample;
   output reg level;
   output reg edge_seen;

   reg sync1_r;
   reg sync2_r;
   reg [3:0] run_r;

   //------------------------------------------------------------
   // synchroniser and filter
   //------------------------------------------------------------
   // filter samples on timer clock ticks, so in stop it keeps rejecting noise only on the peripheral clock
   always @(posedge aclk) begin
      if (!aresetn) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         run_r <= 4'h0;
         level <= 1'b0;
         edge_seen <= 1'b0;
      end else begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
         edge_seen <= 1'b0;
         if (sync2_r == level) begin
            run_r <= 4'h0;
         end else if (!filt_en) begin
            level <= sync2_r;
            edge_seen <= 1'b1;
         end else if (sample) begin
            if (run_r >= FILT_LEN[3:0] - 4'h1) begin
               level <= sync2_r;
               edge_seen <= 1'b1;
               run_r <= 4'h0;
            end else begin
               run_r <= run_r + 4'h1;
            end
         end
      end
   end
endmodule

// [logic/rto_top.v]
// reloadable one-shot timer with AXI4-Lite register access
`timescale 1ns/1ps
`include "rto_consts.vh"
module rto_top #(
   parameter FILT_LEN = `RTO_FILT_LEN
) (
   aclk,
   aresetn,
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready,
   periph_clk_in,
   timer_in,
   halt_state,
   stop_state,
   timer_out,
   timer_out_en,
   timer_irq_req,
   stop_wake_req
);
   input wire aclk;
   input wire aresetn;
   input wire [7:0] s_axi_awaddr;
   input wire s_axi_awvalid;
   output reg s_axi_awready;
   input wire [31:0] s_axi_wdata;
   input wire [3:0] s_axi_wstrb;
   input wire s_axi_wvalid;
   output reg s_axi_wready;
   output reg [1:0] s_axi_bresp;
   output reg s_axi_bvalid;
   input wire s_axi_bready;
   input wire [7:0] s_axi_araddr;
   input wire s_axi_arvalid;
   output reg s_axi_arready;
   output reg [31:0] s_axi_rdata;
   output reg [1:0] s_axi_rresp;
   output reg s_axi_rvalid;
   input wire s_axi_rready;
   input wire periph_clk_in;
   input wire timer_in;
   input wire halt_state;
   input wire stop_state;
   output reg timer_out;
   output reg timer_out_en;
   output reg timer_irq_req;
   output reg stop_wake_req;

   //------------------------------------------------------------
   // helper functions
   //------------------------------------------------------------
   // byte-lane merge for a write
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge[i*8 +: 8] = nw[i*8 +: 8];
            end
         end
      end
   endfunction

   // address decode shared by read and write paths
   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `RTO_OFF_CTRL) || (a == `RTO_OFF_COUNT) ||
            (a == `RTO_OFF_RELOAD) || (a == `RTO_OFF_CMP0) ||
            (a == `RTO_OFF_CMP1) || (a == `RTO_OFF_STAT);
      end
   endfunction

   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   reg [`RTO_CTRL_W-1:0] ctrl_r;
   reg [15:0] count_r;
   reg [15:0] reload_r;
   reg [15:0] cmp0_r;
   reg [15:0] cmp1_r;
   reg [`RTO_STAT_W-1:0] stat_r;
   reg run_r;
   reg pulse_r;
   reg aw_hold_r;
   reg w_hold_r;
   reg [7:0] awaddr_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   reg pc_s1_r;
   reg pc_s2_r;
   reg pc_s3_r;

   wire presc_tick;
   wire in_level;
   wire in_edge;
   wire clksel;
   wire tclk_tick;
   wire do_wr;
   wire [31:0] wr_val;
   wire [31:0] ctrl_m, count_m, reload_m, cmp0_m, cmp1_m;
   wire [15:0] count_nxt;
   wire step;
   wire reload_evt;
   wire cmp0_evt;
   wire cmp1_evt;
   wire irq_evt;
   wire [`RTO_STAT_W-1:0] stat_set;
   wire [`RTO_STAT_W-1:0] stat_clr;

   //------------------------------------------------------------
   // timer clock selection
   //------------------------------------------------------------
   // peripheral clock pin is synchronised; only s2/s3 feed the edge detect
   always @(posedge aclk) begin
      if (!aresetn) begin
         pc_s1_r <= 1'b0;
         pc_s2_r <= 1'b0;
         pc_s3_r <= 1'b0;
      end else begin
         pc_s1_r <= periph_clk_in;
         pc_s2_r <= pc_s1_r;
         pc_s3_r <= pc_s2_r;
      end
   end

   assign clksel = ctrl_r[`RTO_CTRL_CLKSEL];
   // system clock ticks stop in stop state; halt has no effect on them
   assign tclk_tick = clksel ? (pc_s2_r & ~pc_s3_r) : ~stop_state;

   rto_prescale u_presc (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick_in(tclk_tick),
      .run(run_r),
      .sel(ctrl_r[`RTO_CTRL_PRES_HI:`RTO_CTRL_PRES_LO]),
      .tick_out(presc_tick)
   );

   rto_in_filter #(
      .FILT_LEN(FILT_LEN)
   ) u_filt (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(timer_in),
      .filt_en(ctrl_r[`RTO_CTRL_FILTEN]),
      .sample(tclk_tick),
      .level(in_level),
      .edge_seen(in_edge)
   );

   //------------------------------------------------------------
   // counter and events
   //------------------------------------------------------------
   assign count_nxt = count_r + 16'h0001;
   // prescaler may emit a last tick as run drops; gate it here too
   assign step = presc_tick & run_r;
   assign reload_evt = step & (count_nxt == reload_r);
   assign cmp0_evt = step & (count_nxt == cmp0_r);
   assign cmp1_evt = step & (count_nxt == cmp1_r);
   assign irq_evt = reload_evt |
      ((ctrl_r[`RTO_CTRL_ICFG_HI:`RTO_CTRL_ICFG_LO] != `RTO_ICFG_RELOAD_ONLY) &
      (cmp0_evt | cmp1_evt));
   assign stat_set = {in_edge, cmp1_evt, cmp0_evt, reload_evt};

   //------------------------------------------------------------
   // bus write decode
   //------------------------------------------------------------
   assign do_wr = aw_hold_r & w_hold_r & ~s_axi_bvalid;
   assign wr_val = merge(32'h00000000, wdata_r, wstrb_r);
   // merged words are cut back to register width on purpose at the write
   assign ctrl_m = merge({21'h0, ctrl_r}, wdata_r, wstrb_r);
   assign count_m = merge({16'h0000, count_r}, wdata_r, wstrb_r);
   assign reload_m = merge({16'h0000, reload_r}, wdata_r, wstrb_r);
   assign cmp0_m = merge({16'h0000, cmp0_r}, wdata_r, wstrb_r);
   assign cmp1_m = merge({16'h0000, cmp1_r}, wdata_r, wstrb_r);
   assign stat_clr = (do_wr && awaddr_r == `RTO_OFF_STAT) ?
      wr_val[`RTO_STAT_W-1:0] : {`RTO_STAT_W{1'b0}};

   // register file; bus writes win over the counter, hardware sets win status
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= `RTO_CTRL_RST;
         count_r <= `RTO_COUNT_RST;
         reload_r <= `RTO_RELOAD_RST;
         cmp0_r <= 16'h0000;
         cmp1_r <= 16'h0000;
         stat_r <= {`RTO_STAT_W{1'b0}};
      end else begin
         stat_r <= (stat_r & ~stat_clr) | stat_set;
         if (reload_evt) begin
            count_r <= `RTO_COUNT_AFTER_RELOAD;
            ctrl_r[`RTO_CTRL_EN] <= 1'b0;
         end else if (step) begin
            count_r <= count_nxt;
         end
         // registers stay writable whatever the enable state
         if (do_wr) begin
            case (awaddr_r)
               `RTO_OFF_CTRL: ctrl_r <= ctrl_m[`RTO_CTRL_W-1:0];
               `RTO_OFF_COUNT: count_r <= count_m[15:0];
               `RTO_OFF_RELOAD: reload_r <= reload_m[15:0];
               `RTO_OFF_CMP0: cmp0_r <= cmp0_m[15:0];
               `RTO_OFF_CMP1: cmp1_r <= cmp1_m[15:0];
               default: begin
               end
            endcase
         end
      end
   end

   //------------------------------------------------------------
   // run state in the timer clock domain
   //------------------------------------------------------------
   // on peripheral clock the enable only lands on a timer clock tick
   always @(posedge aclk) begin
      if (!aresetn) begin
         run_r <= 1'b0;
      end else if (reload_evt) begin
         run_r <= 1'b0;
      end else if (!clksel || tclk_tick) begin
         run_r <= ctrl_r[`RTO_CTRL_EN];
      end
   end

   //------------------------------------------------------------
   // output pin and requests
   //------------------------------------------------------------
   // pulse lasts from the reload to the next timer clock tick
   always @(posedge aclk) begin
      if (!aresetn) begin
         pulse_r <= 1'b0;
         timer_out <= 1'b0;
         timer_out_en <= 1'b0;
         timer_irq_req <= 1'b0;
         stop_wake_req <= 1'b0;
      end else begin
         if (reload_evt) begin
            pulse_r <= 1'b1;
         end else if (tclk_tick) begin
            pulse_r <= 1'b0;
         end
         timer_out <= ctrl_r[`RTO_CTRL_POL] ^ pulse_r;
         timer_out_en <= ctrl_r[`RTO_CTRL_OUTEN];
         timer_irq_req <= irq_evt & ctrl_r[`RTO_CTRL_IRQEN];
         stop_wake_req <= irq_evt & ctrl_r[`RTO_CTRL_IRQEN] & stop_state &
            clksel;
      end
   end

   //------------------------------------------------------------
   // AXI4-Lite write channel
   //------------------------------------------------------------
   // address and data taken independently; one write in flight at a time
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RTO_RESP_OKAY;
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
      end else begin
         s_axi_awready <= ~aw_hold_r & ~(s_axi_awvalid & s_axi_awready);
         s_axi_wready <= ~w_hold_r & ~(s_axi_wvalid & s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(awaddr_r) ? `RTO_RESP_OKAY : `RTO_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   //------------------------------------------------------------
   // AXI4-Lite read channel
   //------------------------------------------------------------
   // count reads are live; on the peripheral clock they may catch a step
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RTO_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= mapped(s_axi_araddr) ? `RTO_RESP_OKAY : `RTO_RESP_SLVERR;
         case (s_axi_araddr)
            `RTO_OFF_CTRL: s_axi_rdata <= {20'h00000, run_r, ctrl_r};
            `RTO_OFF_COUNT: s_axi_rdata <= {16'h0000, count_r};
            `RTO_OFF_RELOAD: s_axi_rdata <= {16'h0000, reload_r};
            `RTO_OFF_CMP0: s_axi_rdata <= {16'h0000, cmp0_r};
            `RTO_OFF_CMP1: s_axi_rdata <= {16'h0000, cmp1_r};
            `RTO_OFF_STAT: s_axi_rdata <= {27'h0000000, in_level, stat_r};
            default: s_axi_rdata <= 32'h00000000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end else begin
         s_axi_arready <= ~s_axi_rvalid;
      end
   end
endmodule

// [testbench/rto_properties.sv]
// checker: bus handshake and event pulse properties of the one-shot timer
`timescale 1ns/1ps
module rto_properties #(
   parameter FILT_LEN = 4
) (
   input logic aclk,
   input logic aresetn,
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic [1:0] s_axi_bresp,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   input logic stop_state,
   input logic timer_irq_req,
   input logic stop_wake_req
);
   // ----------
   // properties
   // ----------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // both write halves taken at one edge
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // answers waiting on a slow master must not move
   sequence s_b_stall;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   sequence s_r_stall;
      s_axi_rvalid && !s_axi_rready;
   endsequence
   a_b_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   a_b_hold: assert property (s_b_stall |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_r_hold: assert property (s_r_stall |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while busy");
   a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   // one reload gives one request, the timer has already stopped
   a_irq_single: assert property (timer_irq_req |=> !timer_irq_req)
      else $error("interrupt pulse too long");
   a_wake_pulse: assert property (stop_wake_req |=> !stop_wake_req)
      else $error("wake pulse too long");
   a_wake_in_stop: assert property (stop_wake_req |-> stop_state || $past(stop_state))
      else $error("wake outside stop");
endmodule
bind rto_top rto_properties #(.FILT_LEN(FILT_LEN)) u_rto_properties (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .stop_state, .timer_irq_req, .stop_wake_req
);

// [testbench/rto_pins.sv]
// external pin model: peripheral clock source and timer input signal
`timescale 1ns/1ps
module rto_pins (
   input wire run,
   output logic periph_clk_in,
   output logic timer_in
);
   // clock rests low between runs; odd half period keeps it off the bus clock grid
   initial begin
      periph_clk_in = 1'b0;
      forever begin
         #36.7;
         periph_clk_in = run & ~periph_clk_in;
      end
   end
   // input edges spaced far beyond four timer clock periods
   initial begin
      timer_in = 1'b0;
      forever begin
         #600.3;
         if (run) timer_in = ~timer_in;
      end
   end
endmodule

// [testbench/tb.sv]
// testbench: one-shot timer through the register bus and pin model
`timescale 1ns/1ps
`include "rto_consts.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, seed;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic periph_clk_in, timer_in, halt_state, stop_state, pins_run;
   logic timer_out, timer_out_en, timer_irq_req, stop_wake_req;
   int n_fail = 0;
   int n_tests = 0;
   // ----------
   // instances and clock
   // ----------
   // short filter keeps the input-edge scenario brief
   rto_top #(.FILT_LEN(2)) u_rto_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periph_clk_in, .timer_in,
      .halt_state, .stop_state, .timer_out, .timer_out_en, .timer_irq_req, .stop_wake_req);
   rto_pins u_rto_pins (.run(pins_run), .periph_clk_in, .timer_in);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // ----------
   // helpers
   // ----------
   function automatic [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // reload zero spans the whole counter range
   function automatic [31:0] exp_ticks(input [15:0] st, input [15:0] rl, input [2:0] n);
      logic [16:0] span;
      span = (rl == 16'h0000) ? 17'h10000 - st : {1'b0, rl - st};
      exp_ticks = span << n;
   endfunction
   task automatic tally_and_finish;
      if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic hang(input string nm);
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, 1'b1, 1'b0);
      tally_and_finish;
   endtask
   // write: both halves offered together, each released when taken
   task automatic wr(input [7:0] a, input [31:0] v);
      int k;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      // a late response accept now and then makes the slave hold its answer
      s_axi_bready <= ~seed[1];
      k = 0;
      do begin
         @(posedge aclk);
         k++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end while ((s_axi_bvalid & s_axi_bready) !== 1'b1 && k < 40);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if ((s_axi_bvalid & s_axi_bready) !== 1'b1) hang("bus_answer");
   endtask
   task automatic rd(input [7:0] a);
      int k;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= ~seed[0];
      k = 0;
      do begin
         @(posedge aclk);
         k++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end while ((s_axi_rvalid & s_axi_rready) !== 1'b1 && k < 40);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if ((s_axi_rvalid & s_axi_rready) !== 1'b1) hang("bus_answer");
   endtask
   // ----------
   // main sequence
   // ----------
   initial begin
      int n, k, oc;
      logic [15:0] st, rl, df;
      logic [31:0] t, ctl;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      {halt_state, stop_state, pins_run} = 3'h0;
      s_axi_wstrb = 4'hf;
      seed = 32'h2e89407f;
      aresetn = 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`RTO_OFF_CTRL);
      `CHK("ctrl_reset", 32'h0, d)
      rd(8'h18);
      `CHK("unmapped_rd", `RTO_RESP_SLVERR, r)
      wr(8'h18, 32'hffffffff);
      `CHK("unmapped_wr", `RTO_RESP_SLVERR, r)
      // one-shot at every prescale; first two pick wrap, zero reload, shortest span
      for (n = 0; n < 8; n++) begin
         seed = lfsr(seed);
         st = seed[15:0];
         df = {13'h0, seed[18:16]} + 16'h1;
         if (n == 0) {st, df} = {16'hfffd, 16'h3};
         if (n == 1) {st, df} = {16'h0000, 16'h1};
         rl = st + df;
         ctl = 32'h0c0 | (n << 2) | ((n & 1) << 1);
         wr(`RTO_OFF_CTRL, ctl);
         wr(`RTO_OFF_COUNT, {16'h0, st});
         wr(`RTO_OFF_RELOAD, {16'h0, rl});
         wr(`RTO_OFF_CMP0, {16'h0, st + 16'h1});
         halt_state <= seed[20];
         wr(`RTO_OFF_CTRL, ctl | 32'h501);
         t = exp_ticks(st, rl, n[2:0]);
         k = 0;
         oc = 0;
         while (timer_irq_req !== 1'b1 && k < 1100) begin
            @(posedge aclk);
            k++;
            if (timer_out !== ctl[1]) oc++;
         end
         if (timer_irq_req !== 1'b1) hang("irq_wait");
         repeat (4) begin
            @(posedge aclk);
            if (timer_out !== ctl[1]) oc++;
         end
         `CHK("timeout", 1'b1, k + 1 >= t && k <= t + 4)
         `CHK("out_pulse", 1, oc)
         `CHK("out_en", 1'b1, timer_out_en)
         rd(`RTO_OFF_COUNT);
         `CHK("count_after", 32'h1, d)
         rd(`RTO_OFF_CTRL);
         `CHK("en_cleared", 2'b00, {d[11], d[0]})
         rd(`RTO_OFF_STAT);
         `CHK("reload_flag", 1'b1, d[0])
         wr(`RTO_OFF_STAT, 32'hf);
      end
      // system clock frozen in stop, resumes after; disable holds, writes still land
      halt_state <= 1'b1;
      wr(`RTO_OFF_RELOAD, 32'h0);
      wr(`RTO_OFF_COUNT, 32'h0);
      wr(`RTO_OFF_CTRL, 32'h001);
      repeat (20) @(posedge aclk);
      stop_state <= 1'b1;
      repeat (3) @(posedge aclk);
      rd(`RTO_OFF_COUNT);
      st = d[15:0];
      repeat (30) @(posedge aclk);
      rd(`RTO_OFF_COUNT);
      `CHK("stop_freeze", st, d[15:0])
      stop_state <= 1'b0;
      repeat (10) @(posedge aclk);
      rd(`RTO_OFF_COUNT);
      `CHK("resume", 1'b1, d[15:0] != st)
      wr(`RTO_OFF_CTRL, 32'h0);
      rd(`RTO_OFF_COUNT);
      st = d[15:0];
      repeat (10) @(posedge aclk);
      rd(`RTO_OFF_COUNT);
      `CHK("dis_hold", st, d[15:0])
      wr(`RTO_OFF_COUNT, 32'h1234);
      rd(`RTO_OFF_COUNT);
      `CHK("dis_write", 32'h1234, d)
      // peripheral clock in stop: reload wakes; control changed only while disabled
      wr(`RTO_OFF_CTRL, 32'h6e0);
      wr(`RTO_OFF_COUNT, 32'h0);
      wr(`RTO_OFF_RELOAD, 32'h3);
      pins_run <= 1'b1;
      stop_state <= 1'b1;
      wr(`RTO_OFF_CTRL, 32'h6e1);
      k = 0;
      while (stop_wake_req !== 1'b1 && k < 400) begin
         @(posedge aclk);
         k++;
      end
      if (stop_wake_req !== 1'b1) hang("wake_wait");
      `CHK("wake", 1'b1, stop_wake_req)
      repeat (150) @(posedge aclk);
      pins_run <= 1'b0;
      stop_state <= 1'b0;
      rd(`RTO_OFF_COUNT);
      `CHK("count_periph", 32'h1, d)
      rd(`RTO_OFF_STAT);
      `CHK("input_edge", 1'b1, d[3])
      tally_and_finish;
   end
endmodule
